//--- inc/muldiv_pkg.sv
// Shared constants for the multiply/divide unit
`default_nettype none
package muldiv_pkg;
	// Operation codes on issue_op
	localparam logic [3:0] OP_PRODUCT_TO_GPR           = 4'h0;
	localparam logic [3:0] OP_PRODUCT_TO_ACC           = 4'h1;
	localparam logic [3:0] OP_PRODUCT_TO_ACC_UNSIGNED  = 4'h2;
	localparam logic [3:0] OP_PRODUCT_ADD_ACC          = 4'h3;
	localparam logic [3:0] OP_PRODUCT_ADD_ACC_UNSIGNED = 4'h4;
	localparam logic [3:0] OP_PRODUCT_SUB_ACC          = 4'h5;
	localparam logic [3:0] OP_PRODUCT_SUB_ACC_UNSIGNED = 4'h6;
	localparam logic [3:0] OP_DIVIDE                   = 4'h7;
	localparam logic [3:0] OP_DIVIDE_UNSIGNED          = 4'h8;

	// Iteration counts
	localparam logic [5:0] MUL_ITERS     = 6'h20;
	localparam logic [5:0] DIV_ITERS     = 6'h20;
	localparam logic [5:0] SKIP_FROM_24  = 6'h07;
	localparam logic [5:0] SKIP_FROM_16  = 6'h0F;
	localparam logic [5:0] SKIP_FROM_8   = 6'h17;

	// Reset values
	localparam logic [31:0] ACC_RESET    = 32'h0000_0000;
endpackage
`default_nettype wire

//--- hw/muldiv_unit.sv
// Multiply/divide unit with high/low accumulator, pipelined or compact build
// Function
// - Pipelined: 32x16 multiply accepted every clock
// - Pipelined: 32x32 multiply to accumulator issues every second cycle
// - Pipelined divide one bit per clock, max 33 stall cycles
// - Early-in skips 7, 15 or 23 iterations
// - Pipelined: stall new ops during divide
// - Compact multiply iterates 32 clocks, one adder
// - Compact divide always 33 stall cycles, no skip
// - Compact: stall new ops while busy
// - Product-to-register writes low 32 bits only
// - Multiply-add adds product into accumulator
// - Multiply-subtract subtracts product from accumulator
// - Compact stall 31 plain, 33 accumulate
// - Pipelined 32x32 to register stalls two
`timescale 1ns/1ps
`default_nettype none
module muldiv_unit #(
	parameter bit PIPELINED = 1'b1
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Instruction issue
	input  wire logic        issue_valid,
	input  wire logic [3:0]  issue_op,
	input  wire logic [31:0] operand_a,
	input  wire logic [31:0] operand_b,
	output logic             stall,
	// Accumulator read
	input  wire logic        acc_read,
	input  wire logic        acc_read_upper,
	output logic             acc_read_valid,
	output logic [31:0]      acc_read_data,
	// Register file write
	output logic             gpr_write_valid,
	output logic [31:0]      gpr_write_data
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_MPASS, ST_MHOLD, ST_MITER, ST_MACC_LO, ST_MACC_HI, ST_DITER, ST_DFIX
	} state_t;

	function automatic logic is_unsigned(input logic [3:0] op);
		return op == muldiv_pkg::OP_PRODUCT_TO_ACC_UNSIGNED ||
			op == muldiv_pkg::OP_PRODUCT_ADD_ACC_UNSIGNED ||
			op == muldiv_pkg::OP_PRODUCT_SUB_ACC_UNSIGNED ||
			op == muldiv_pkg::OP_DIVIDE_UNSIGNED;
	endfunction

	function automatic logic is_accum(input logic [3:0] op);
		return op == muldiv_pkg::OP_PRODUCT_ADD_ACC ||
			op == muldiv_pkg::OP_PRODUCT_ADD_ACC_UNSIGNED ||
			op == muldiv_pkg::OP_PRODUCT_SUB_ACC ||
			op == muldiv_pkg::OP_PRODUCT_SUB_ACC_UNSIGNED;
	endfunction

	function automatic logic is_sub(input logic [3:0] op);
		return op == muldiv_pkg::OP_PRODUCT_SUB_ACC ||
			op == muldiv_pkg::OP_PRODUCT_SUB_ACC_UNSIGNED;
	endfunction

	function automatic logic [31:0] magnitude(input logic [31:0] v, input logic sgn);
		return (sgn && v[31]) ? 32'(-v) : v;
	endfunction

	// One pass of the 32x16 array, sign extended to 64 bits
	function automatic logic [63:0] array_pass(input logic [32:0] a, input logic [16:0] b);
		logic signed [49:0] p;
		p = $signed(a) * $signed(b);
		return {{14{p[49]}}, p};
	endfunction

	// Shift-add step: one 32-bit add, returns {partial_hi, multiplier}
	function automatic logic [63:0] mul_step(input logic [31:0] ph, input logic [31:0] mlr,
		input logic [31:0] mc);
		logic [32:0] sum;
		sum = {1'b0, ph} + {1'b0, (mlr[0] ? mc : 32'h0000_0000)};
		return {sum, mlr[31:1]};
	endfunction

	// Restoring divide step: returns {remainder, shifted dividend with quotient bit}
	function automatic logic [63:0] div_step(input logic [31:0] rem, input logic [31:0] dq,
		input logic [31:0] dv);
		logic [33:0] t;
		t = {1'b0, rem, dq[31]} - {2'b00, dv};
		return {(t[33] ? {rem[30:0], dq[31]} : t[31:0]), dq[30:0], ~t[33]};
	endfunction

	state_t      state_q, state_d;
	logic [5:0]  cnt_q;
	logic [3:0]  op_q;
	logic [31:0] mc_q;
	logic [31:0] hi_q;
	logic [31:0] lo_q;
	logic [32:0] a33_q;
	logic [16:0] bhi_q;
	logic [63:0] p1_q;
	logic        qneg_q;
	logic        rneg_q;
	logic        wb_valid_q;
	logic [3:0]  wb_op_q;
	logic [63:0] wb_val_q;
	logic [31:0] acc_upper_q, acc_upper_d;
	logic [31:0] acc_bottom_q, acc_bottom_d;

	logic        accept;
	logic        op_known;
	logic        op_div;
	logic        sgn;
	logic        fits16;
	logic        big_gpr;
	logic [32:0] a33;
	logic [16:0] blo17;
	logic [16:0] bhi17;
	logic [31:0] mag_a, mag_b;
	logic [5:0]  skip;
	logic [63:0] first_step;
	logic [63:0] iter_step;
	logic [63:0] dstep;
	logic [63:0] mag_prod;
	logic [63:0] acc_full;
	logic [63:0] second_pass;

	assign op_known = issue_op <= muldiv_pkg::OP_DIVIDE_UNSIGNED;
	// Issue only while idle; stall is this state seen through a flop
	assign accept   = issue_valid && op_known && !stall;
	assign op_div   = issue_op == muldiv_pkg::OP_DIVIDE ||
		issue_op == muldiv_pkg::OP_DIVIDE_UNSIGNED;
	assign sgn      = !is_unsigned(issue_op);
	assign a33      = {sgn & operand_a[31], operand_a};
	assign fits16   = sgn ? (&operand_b[31:15] || ~|operand_b[31:15]) : ~|operand_b[31:16];
	assign blo17    = {sgn & fits16 & operand_b[15], operand_b[15:0]};
	assign bhi17    = {sgn & operand_b[31], operand_b[31:16]};
	assign big_gpr  = issue_op == muldiv_pkg::OP_PRODUCT_TO_GPR;
	assign mag_a    = magnitude(operand_a, sgn);
	assign mag_b    = magnitude(operand_b, sgn);
	assign first_step = mul_step(32'h0000_0000, mag_b, mag_a);
	assign iter_step  = mul_step(hi_q, lo_q, mc_q);
	assign dstep      = div_step(hi_q, lo_q, mc_q);
	assign mag_prod   = {hi_q, lo_q};
	// Upper multiplier half against the held multiplicand
	assign second_pass = array_pass(a33_q, bhi_q);

	// Early-in: smallest significant width wins
	always_comb begin
		skip = 6'h00;
		if (PIPELINED) begin
			if (sgn ? (&operand_a[31:7] || ~|operand_a[31:7]) : ~|operand_a[31:8])
				skip = muldiv_pkg::SKIP_FROM_8;
			else if (sgn ? (&operand_a[31:15] || ~|operand_a[31:15]) : ~|operand_a[31:16])
				skip = muldiv_pkg::SKIP_FROM_16;
			else if (sgn ? (&operand_a[31:23] || ~|operand_a[31:23]) : ~|operand_a[31:24])
				skip = muldiv_pkg::SKIP_FROM_24;
		end
	end

	// Control sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (accept) begin
					if (op_div)
						state_d = ST_DITER;
					else if (!PIPELINED)
						state_d = ST_MITER;
					else if (!fits16)
						state_d = ST_MPASS;
				end
			end
			ST_MPASS:   state_d = (op_q == muldiv_pkg::OP_PRODUCT_TO_GPR) ? ST_MHOLD : ST_IDLE;
			ST_MHOLD:   state_d = ST_IDLE;
			ST_MITER: begin
				if (cnt_q == muldiv_pkg::MUL_ITERS - 6'h01)
					state_d = is_accum(op_q) ? ST_MACC_LO : ST_IDLE;
			end
			ST_MACC_LO: state_d = ST_MACC_HI;
			ST_MACC_HI: state_d = ST_IDLE;
			ST_DITER: begin
				if (cnt_q == 6'h01)
					state_d = ST_DFIX;
			end
			ST_DFIX:    state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			stall   <= 1'b0;
		end else begin
			state_q <= state_d;
			stall   <= state_d != ST_IDLE;
		end
	end

	// Iterative datapath and array operands
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= 6'h00;
			op_q   <= muldiv_pkg::OP_PRODUCT_TO_GPR;
			mc_q   <= 32'h0000_0000;
			hi_q   <= 32'h0000_0000;
			lo_q   <= 32'h0000_0000;
			a33_q  <= 33'h0_0000_0000;
			bhi_q  <= 17'h0_0000;
			p1_q   <= 64'h0000_0000_0000_0000;
			qneg_q <= 1'b0;
			rneg_q <= 1'b0;
		end else if (accept) begin
			op_q   <= issue_op;
			a33_q  <= a33;
			bhi_q  <= bhi17;
			p1_q   <= array_pass(a33, blo17);
			qneg_q <= sgn && (operand_a[31] ^ operand_b[31]);
			rneg_q <= sgn && operand_a[31];
			if (op_div) begin
				mc_q  <= mag_b;
				hi_q  <= 32'h0000_0000;
				lo_q  <= mag_a << skip;
				cnt_q <= muldiv_pkg::DIV_ITERS - skip;
			end else begin
				// First shift-add step happens in the issue cycle
				mc_q  <= mag_a;
				hi_q  <= first_step[63:32];
				lo_q  <= first_step[31:0];
				cnt_q <= 6'h01;
			end
		end else if (state_q == ST_MITER) begin
			hi_q  <= iter_step[63:32];
			lo_q  <= iter_step[31:0];
			cnt_q <= cnt_q + 6'h01;
		end else if (state_q == ST_DITER) begin
			hi_q  <= dstep[63:32];
			lo_q  <= dstep[31:0];
			cnt_q <= cnt_q - 6'h01;
		end
	end

	// Completion stage: one slot that finishes add, accumulate or write
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_valid_q <= 1'b0;
			wb_op_q    <= muldiv_pkg::OP_PRODUCT_TO_GPR;
			wb_val_q   <= 64'h0000_0000_0000_0000;
		end else begin
			wb_valid_q <= 1'b0;
			if (accept && PIPELINED && !op_div && fits16) begin
				wb_valid_q <= 1'b1;
				wb_op_q    <= issue_op;
				wb_val_q   <= array_pass(a33, blo17);
			end else if (state_q == ST_MPASS) begin
				wb_valid_q <= 1'b1;
				wb_op_q    <= op_q;
				wb_val_q   <= 64'(p1_q + {second_pass[47:0], 16'h0000});
			end else if (state_q == ST_MITER && state_d == ST_IDLE) begin
				// Last shift-add lands on this edge, so take the step itself
				wb_valid_q <= 1'b1;
				wb_op_q    <= op_q;
				wb_val_q   <= qneg_q ? 64'(-iter_step) : iter_step;
			end else if (state_q == ST_MACC_HI) begin
				wb_valid_q <= 1'b1;
				wb_op_q    <= op_q;
				wb_val_q   <= qneg_q ? 64'(-mag_prod) : mag_prod;
			end else if (state_q == ST_DFIX) begin
				wb_valid_q <= 1'b1;
				wb_op_q    <= op_q;
				wb_val_q   <= {(rneg_q ? 32'(-hi_q) : hi_q), (qneg_q ? 32'(-lo_q) : lo_q)};
			end
		end
	end

	// Accumulator next value, also forwarded to reads
	assign acc_full = {acc_upper_q, acc_bottom_q};
	always_comb begin
		acc_upper_d  = acc_upper_q;
		acc_bottom_d = acc_bottom_q;
		if (wb_valid_q && wb_op_q != muldiv_pkg::OP_PRODUCT_TO_GPR) begin
			if (is_accum(wb_op_q) && is_sub(wb_op_q))
				{acc_upper_d, acc_bottom_d} = 64'(acc_full - wb_val_q);
			else if (is_accum(wb_op_q))
				{acc_upper_d, acc_bottom_d} = 64'(acc_full + wb_val_q);
			else
				{acc_upper_d, acc_bottom_d} = wb_val_q;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_upper_q  <= muldiv_pkg::ACC_RESET;
			acc_bottom_q <= muldiv_pkg::ACC_RESET;
		end else begin
			acc_upper_q  <= acc_upper_d;
			acc_bottom_q <= acc_bottom_d;
		end
	end

	// Register file write of the low product word
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gpr_write_valid <= 1'b0;
			gpr_write_data  <= 32'h0000_0000;
		end else begin
			gpr_write_valid <= wb_valid_q && wb_op_q == muldiv_pkg::OP_PRODUCT_TO_GPR;
			if (wb_valid_q && wb_op_q == muldiv_pkg::OP_PRODUCT_TO_GPR)
				gpr_write_data <= wb_val_q[31:0];
		end
	end

	// Reads are refused while busy; the one taken sees any write in flight
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_read_valid <= 1'b0;
			acc_read_data  <= 32'h0000_0000;
		end else begin
			acc_read_valid <= acc_read && !stall;
			if (acc_read && !stall)
				acc_read_data <= acc_read_upper ? acc_upper_d : acc_bottom_d;
		end
	end
endmodule
`default_nettype wire

//--- test/muldiv_unit_props.sv
// Port-level timing checks for the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module muldiv_unit_props #(
	parameter bit PIPELINED = 1'b1
) (
	// Clock, reset and issue
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        issue_valid,
	input wire logic [3:0]  issue_op,
	input wire logic [31:0] operand_a,
	input wire logic [31:0] operand_b,
	input wire logic        stall,
	// Results
	input wire logic        acc_read,
	input wire logic        acc_read_upper,
	input wire logic        acc_read_valid,
	input wire logic [31:0] acc_read_data,
	input wire logic        gpr_write_valid,
	input wire logic [31:0] gpr_write_data
);
	// Pipelined timing only; the compact build has other figures
	wire go = PIPELINED && issue_valid && !stall;
	wire wide = !operand_b[31] && operand_b[30:16] != 15'h0000;
	wire narrow = operand_b[31:15] == 17'h00000;
	wire mac = issue_op >= muldiv_pkg::OP_PRODUCT_TO_ACC
		&& issue_op <= muldiv_pkg::OP_PRODUCT_SUB_ACC_UNSIGNED;
	wire div = go && issue_op == muldiv_pkg::OP_DIVIDE;
	wire to_gpr = go && issue_op == muldiv_pkg::OP_PRODUCT_TO_GPR;
	// Compact build: one adder, so every op holds the unit for its full count
	wire cgo = !PIPELINED && issue_valid && !stall;
	wire c_plain = cgo && issue_op <= muldiv_pkg::OP_PRODUCT_TO_ACC_UNSIGNED;
	wire c_acc = cgo && mac && issue_op >= muldiv_pkg::OP_PRODUCT_ADD_ACC;
	wire c_div = cgo && (issue_op == muldiv_pkg::OP_DIVIDE
		|| issue_op == muldiv_pkg::OP_DIVIDE_UNSIGNED);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (acc_read && !stall |=> acc_read_valid)
		else $error("taken read gave no answer");
	a_read_refused: assert property (!(acc_read && !stall) |=> !acc_read_valid)
		else $error("read answered while busy or idle");
	a_gpr_short: assert property (to_gpr && narrow |-> ##2 (gpr_write_valid
		&& gpr_write_data == $past(operand_a, 2) * $past(operand_b, 2)))
		else $error("short register product wrong or late");
	a_gpr_long: assert property (to_gpr && wide |=> stall ##1 stall ##1 (!stall
		&& gpr_write_valid && gpr_write_data == $past(operand_a, 3) * $past(operand_b, 3)))
		else $error("wide register product timing wrong");
	a_narrow_free: assert property (go && (mac || to_gpr) && narrow |=> !stall)
		else $error("narrow multiply stalled");
	a_wide_interlock: assert property (go && mac && wide |=> stall ##1 !stall)
		else $error("wide multiply interlock wrong");
	a_div_byte: assert property (div && (operand_a[31:7] == 25'h0000000
		|| &operand_a[31:7]) |=> stall [*8] ##1 stall ##1 stall ##1 !stall)
		else $error("byte dividend skip wrong");
	a_div_full: assert property (div && operand_a[31] != operand_a[30]
		|=> stall [*8] ##25 stall ##1 !stall) else $error("full divide length wrong");
	a_compact_mul: assert property (c_plain |=> stall ##30 stall ##1 !stall)
		else $error("compact multiply length wrong");
	a_compact_mac: assert property (c_acc |=> stall ##32 stall ##1 !stall)
		else $error("compact accumulate length wrong");
	a_compact_div: assert property (c_div |=> stall ##32 stall ##1 !stall)
		else $error("compact divide length wrong");
	a_read_hold: assert property (!(acc_read && !stall) |=> $stable(acc_read_data))
		else $error("read data moved without a read");
	a_gpr_hold: assert property ($changed(gpr_write_data) |-> gpr_write_valid)
		else $error("register data moved without a write");
endmodule
bind muldiv_unit muldiv_unit_props #(.PIPELINED(PIPELINED)) i_muldiv_unit_props (
	.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .issue_op(issue_op),
	.operand_a(operand_a), .operand_b(operand_b), .stall(stall), .acc_read(acc_read),
	.acc_read_upper(acc_read_upper), .acc_read_valid(acc_read_valid),
	.acc_read_data(acc_read_data), .gpr_write_valid(gpr_write_valid),
	.gpr_write_data(gpr_write_data));
`default_nettype wire

//--- test/issue_model.sv
// Issue pipeline model that feeds the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module issue_model (
	// Clock and unit status
	input wire logic        clock,
	input wire logic        stall,
	input wire logic        acc_read_valid,
	input wire logic [31:0] acc_read_data,
	// Requests
	output var logic        issue_valid,
	output var logic [3:0]  issue_op,
	output var logic [31:0] operand_a,
	output var logic [31:0] operand_b,
	output var logic        acc_read,
	output var logic        acc_read_upper
);
	initial begin
		issue_valid = 1'b0;
		issue_op = 4'hF;
		operand_a = 32'h0000_0000;
		operand_b = 32'h0000_0000;
		acc_read = 1'b0;
		acc_read_upper = 1'b0;
	end
	// Idle operands flip so a stale value never looks valid
	task automatic quiet;
		@(negedge clock);
		issue_valid = 1'b0;
		operand_a = ~operand_a;
		operand_b = ~operand_b;
	endtask
	task automatic issue(input logic [3:0] o, input logic [31:0] x, input logic [31:0] y);
		@(negedge clock);
		issue_valid = 1'b1;
		issue_op = o;
		operand_a = x;
		operand_b = y;
		// Stall only moves on rising edges, so the falling edge sees it settled
		while (stall !== 1'b0) @(negedge clock);
		@(posedge clock);
	endtask
	task automatic read(input logic upper, output logic valid, output logic [31:0] data);
		quiet();
		acc_read = 1'b1;
		acc_read_upper = upper;
		while (stall !== 1'b0) @(negedge clock);
		@(posedge clock);
		@(negedge clock);
		valid = acc_read_valid;
		data = acc_read_data;
		acc_read = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- test/muldiv_unit_tb.sv
// Self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module muldiv_unit_tb;
	logic        clock;
	logic        rst_n;
	logic        issue_valid;
	logic [3:0]  issue_op;
	logic [31:0] operand_a;
	logic [31:0] operand_b;
	logic        stall;
	logic        acc_read;
	logic        acc_read_upper;
	logic        acc_read_valid;
	logic [31:0] acc_read_data;
	logic        gpr_write_valid;
	logic [31:0] gpr_write_data;
	logic        issue_valid_c;
	logic [3:0]  issue_op_c;
	logic [31:0] operand_a_c;
	logic [31:0] operand_b_c;
	logic        stall_c;
	logic        acc_read_c;
	logic        acc_read_upper_c;
	logic        acc_read_valid_c;
	logic [31:0] acc_read_data_c;
	logic        gpr_write_valid_c;
	logic [31:0] gpr_write_data_c;
	bit          compact;
	logic        gv;
	logic [31:0] gd;
	int          fails;
	int          checks;
	logic [63:0] acc_q;
	logic [63:0] p64;
	logic [31:0] got;
	logic [31:0] a;
	logic [31:0] b;
	logic        ok;
	initial clock = 1'b0;
	always #2 clock = ~clock;
	muldiv_unit #(.PIPELINED(1'b1)) i_muldiv_unit (.clock(clock), .rst_n(rst_n),
		.issue_valid(issue_valid), .issue_op(issue_op), .operand_a(operand_a),
		.operand_b(operand_b), .stall(stall), .acc_read(acc_read),
		.acc_read_upper(acc_read_upper), .acc_read_valid(acc_read_valid),
		.acc_read_data(acc_read_data), .gpr_write_valid(gpr_write_valid),
		.gpr_write_data(gpr_write_data));
	issue_model i_issue_model (.clock(clock), .stall(stall), .acc_read_valid(acc_read_valid),
		.acc_read_data(acc_read_data), .issue_valid(issue_valid), .issue_op(issue_op),
		.operand_a(operand_a), .operand_b(operand_b), .acc_read(acc_read),
		.acc_read_upper(acc_read_upper));
	muldiv_unit #(.PIPELINED(1'b0)) i_muldiv_unit_compact (.clock(clock), .rst_n(rst_n),
		.issue_valid(issue_valid_c), .issue_op(issue_op_c), .operand_a(operand_a_c),
		.operand_b(operand_b_c), .stall(stall_c), .acc_read(acc_read_c),
		.acc_read_upper(acc_read_upper_c), .acc_read_valid(acc_read_valid_c),
		.acc_read_data(acc_read_data_c), .gpr_write_valid(gpr_write_valid_c),
		.gpr_write_data(gpr_write_data_c));
	issue_model i_issue_model_compact (.clock(clock), .stall(stall_c),
		.acc_read_valid(acc_read_valid_c), .acc_read_data(acc_read_data_c),
		.issue_valid(issue_valid_c), .issue_op(issue_op_c), .operand_a(operand_a_c),
		.operand_b(operand_b_c), .acc_read(acc_read_c), .acc_read_upper(acc_read_upper_c));
	// Result watch follows whichever build is under test
	assign gv = compact ? gpr_write_valid_c : gpr_write_valid;
	assign gd = compact ? gpr_write_data_c : gpr_write_data;
	function automatic logic [63:0] product(input logic [3:0] o, input logic [31:0] x,
		input logic [31:0] y);
		logic s;
		s = o != 4'h2 && o != 4'h4 && o != 4'h6;
		return {{32{s & x[31]}}, x} * {{32{s & y[31]}}, y};
	endfunction
	function automatic logic [63:0] next_acc(input logic [3:0] o, input logic [31:0] x,
		input logic [31:0] y, input logic [63:0] acc);
		case (o)
			muldiv_pkg::OP_DIVIDE: return {$signed(x) % $signed(y), $signed(x) / $signed(y)};
			muldiv_pkg::OP_DIVIDE_UNSIGNED: return {x % y, x / y};
			4'h3, 4'h4: return acc + product(o, x, y);
			4'h5, 4'h6: return acc - product(o, x, y);
			muldiv_pkg::OP_PRODUCT_TO_GPR: return acc;
			default: return product(o, x, y);
		endcase
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic put(input logic [3:0] o, input logic [31:0] x, input logic [31:0] y);
		if (compact)
			i_issue_model_compact.issue(o, x, y);
		else
			i_issue_model.issue(o, x, y);
	endtask
	task automatic get(input logic upper);
		if (compact)
			i_issue_model_compact.read(upper, ok, got);
		else
			i_issue_model.read(upper, ok, got);
	endtask
	task automatic idle;
		if (compact)
			i_issue_model_compact.quiet();
		else
			i_issue_model.quiet();
	endtask
	task automatic check_acc;
		get(1'b1);
		cmp({31'h0, ok}, 32'h0000_0001);
		cmp(got, acc_q[63:32]);
		get(1'b0);
		cmp(got, acc_q[31:0]);
	endtask
	// Back to back, the second held through the first one's stall
	task automatic twice(input logic [3:0] o1, input logic [3:0] o2);
		put(o1, a, b);
		put(o2, b, a);
		acc_q = next_acc(o2, b, a, next_acc(o1, a, b, acc_q));
		check_acc();
	endtask
	// Same mix for each build; the accumulator model restarts from reset
	task automatic run;
		acc_q = 64'h0;
		check_acc();
		for (int i = 0; i < 54; i++) begin
			a = $urandom;
			case ((i / 9) % 4)
				0: a = {{24{a[7]}}, a[7:0]};
				1: a = {{16{a[15]}}, a[15:0]};
				2: a = {{8{a[23]}}, a[23:0]};
				default: a[30] = ~a[31];
			endcase
			b = (i % 2) ? $urandom : ($urandom & 32'h0000_7FFF);
			if (b == 32'h0 || &b) b = 32'h0000_0003;
			put(4'(i % 9), a, b);
			if (i % 9 == 0) begin
				idle();
				for (int n = 0; n < 40 && gv !== 1'b1; n++) @(negedge clock);
				p64 = product(4'h0, a, b);
				cmp({31'h0, gv}, 32'h0000_0001);
				cmp(gd, p64[31:0]);
			end
			acc_q = next_acc(4'(i % 9), a, b, acc_q);
			check_acc();
		end
		a = $urandom;
		b = 32'h1234_5678;
		twice(muldiv_pkg::OP_PRODUCT_TO_ACC, muldiv_pkg::OP_PRODUCT_ADD_ACC);
		twice(muldiv_pkg::OP_DIVIDE, muldiv_pkg::OP_PRODUCT_SUB_ACC);
	endtask
	task automatic end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		// Two builds of roughly 3000 cycles together, with wide margin
		#100000;
		fails++;
		end_of_test();
	end
	initial begin
		rst_n = 1'b0;
		fails = 0;
		checks = 0;
		compact = 1'b0;
		void'($urandom(1));
		repeat (2) @(posedge clock);
		@(negedge clock) rst_n = 1'b1;
		run();
		compact = 1'b1;
		run();
		end_of_test();
	end
endmodule
`default_nettype wire
